/* File: hw/nvb_access.sv */
// Purpose: Byte access logic between CPU I/O registers and a data array
// Assumes: One CPU access per cycle; osc_clk_i is the calibrated oscillator
// Notes:   Array contents are kept across reset; the array model has no reset
//
// Contract
// [RULE1] A separate 512-byte data space, each byte read or written alone.
// [RULE2] The byte address is a 9-bit linear value, 0 to 511.
// [RULE3] Address bits 15..9 read as zero, writes to them ignored.
// [RULE4] Software loads a valid address before any read or write.
// [RULE5] A read strobe stalls the CPU for four cycles.
// [RULE6] A started write stalls the CPU for two cycles.
// [RULE7] Writes are self-timed; the write strobe bit polls completion.
// [RULE8] Write strobes without the arming sequence are ignored.
// [RULE9] A write programs the data byte into the addressed location.
// [RULE10] A read loads the data byte from the addressed location.
// [RULE11] Address, data and control registers sit in the I/O space.
// [RULE12] Master arm clears after four cycles; strobes count only while set. Read strobes are accepted without it.
// [RULE13] Each write lasts 8448 oscillator cycles, then clears its strobe.
// [RULE14] A read strobe makes the byte available at once.
// [RULE15] During a write, read strobes and address writes are ignored.
// [RULE16] The data byte is readable and writable at any time.
`timescale 1ns/10ps

module nvb_access
#(
	parameter int ADDR_W        = nvb_pkg::NV_ADDR_W,
	parameter int WR_OSC_CYCLES = nvb_pkg::WRITE_OSC_CYC
)
(
	input  wire logic                        sys_clk_i,
	input  wire logic                        rst_i,
	input  wire logic                        ce_i,
	input  wire logic [nvb_pkg::IO_ADDR_W-1:0] io_addr_i,
	input  wire logic                        io_we_i,
	input  wire logic                        io_re_i,
	input  wire logic [7:0]                  io_wdata_i,
	input  wire logic                        osc_clk_i,
	output logic      [7:0]                  io_rdata_o,
	output logic                             cpu_stall_o,
	output logic                             write_busy_o
);
	import nvb_pkg::*;

	localparam int DEPTH = 1 << ADDR_W;
	localparam int OSC_W = $clog2(WR_OSC_CYCLES + 1);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	generate
		if (ADDR_W < 9 || ADDR_W > 16)
		begin : g_bad_addr
			$error("ADDR_W must lie between 9 and 16");
		end
		if (WR_OSC_CYCLES < 1)
		begin : g_bad_osc
			$error("WR_OSC_CYCLES must be at least 1");
		end
	endgenerate

	// ************************************************************
	// State
	// ************************************************************
	logic [7:0]        mem_r [DEPTH];   // [RULE1]
	logic [ADDR_W-1:0] addr_r;
	logic [ADDR_W-1:0] addr_nxt;
	logic [7:0]        data_r;
	logic [7:0]        data_nxt;
	logic              arm_r;
	logic              arm_nxt;
	logic [2:0]        arm_cnt_r;
	logic [2:0]        arm_cnt_nxt;
	logic [2:0]        stall_cnt_r;
	logic [2:0]        stall_cnt_nxt;
	nvb_state_t        state_r;
	nvb_state_t        state_nxt;
	logic [OSC_W-1:0]  osc_cnt_r;
	logic [OSC_W-1:0]  osc_cnt_nxt;
	logic [ADDR_W-1:0] wr_addr_r;
	logic [7:0]        wr_data_r;
	logic              osc_s1_r;
	logic              osc_s2_r;
	logic              osc_s3_r;
	logic [7:0]        rdata_nxt;

	// ************************************************************
	// Access decode
	// ************************************************************
	wire hit_ctrl  = (io_addr_i == OFS_NV_CONTROL);    // [RULE11]
	wire hit_data  = (io_addr_i == OFS_NV_DATA_BYTE);
	wire hit_alow  = (io_addr_i == OFS_NV_ADDR_LOW);
	wire hit_ahigh = (io_addr_i == OFS_NV_ADDR_HIGH);
	wire busy      = (state_r == NVB_PROG);
	wire ctrl_wr   = io_we_i && hit_ctrl;

	// Strobe acceptance
	wire set_arm   = ctrl_wr && io_wdata_i[BIT_MASTER_ARM];
	wire wr_start  = ctrl_wr && io_wdata_i[BIT_WRITE_STROBE] && arm_r && !busy; // [RULE8] [RULE12]
	wire rd_start  = ctrl_wr && io_wdata_i[BIT_READ_STROBE] && !busy;          // [RULE15]

	// Oscillator edge seen through the synchroniser
	wire osc_tick  = osc_s2_r && !osc_s3_r;
	wire wr_done   = busy && osc_tick && (osc_cnt_r == OSC_W'(1));             // [RULE13]

	// Read-back words
	wire [15:0] addr_wide = 16'(addr_r);
	wire [7:0]  ctrl_word = {5'h00, arm_r, busy, 1'b0};                        // [RULE7]

	// ************************************************************
	// Address register
	// ************************************************************
	always_comb
	begin
		addr_nxt = addr_r;
		if (io_we_i && !busy && hit_alow)                                      // [RULE15]
		begin
			addr_nxt = ADDR_W'({addr_wide[15:8], io_wdata_i});             // [RULE2]
		end
		else if (io_we_i && !busy && hit_ahigh)
		begin
			addr_nxt = ADDR_W'({io_wdata_i, addr_wide[7:0]});              // [RULE3]
		end
	end

	// ************************************************************
	// Data register
	// ************************************************************
	always_comb
	begin
		data_nxt = data_r;
		if (io_we_i && hit_data)                                               // [RULE16]
		begin
			data_nxt = io_wdata_i;
		end
		else if (rd_start)
		begin
			data_nxt = mem_r[addr_r];                                      // [RULE10] [RULE14]
		end
	end

	// ************************************************************
	// Master arm window
	// ************************************************************
	always_comb
	begin
		arm_nxt     = arm_r;
		arm_cnt_nxt = arm_cnt_r;
		if (set_arm)
		begin
			arm_nxt     = 1'b1;
			arm_cnt_nxt = ARM_HOLD_CYC;
		end
		else if (arm_r)
		begin
			arm_cnt_nxt = arm_cnt_r - 3'h1;
			arm_nxt     = (arm_cnt_r != 3'h1);                         // [RULE12]
		end
	end

	// ************************************************************
	// CPU stall counter
	// ************************************************************
	always_comb
	begin
		stall_cnt_nxt = (stall_cnt_r != 3'h0) ? stall_cnt_r - 3'h1 : 3'h0;
		if (rd_start)
		begin
			stall_cnt_nxt = READ_STALL_CYC;                                // [RULE5]
		end
		else if (wr_start)
		begin
			stall_cnt_nxt = WRITE_STALL_CYC;                               // [RULE6]
		end
	end

	// ************************************************************
	// Write engine
	// ************************************************************
	always_comb
	begin
		state_nxt   = state_r;
		osc_cnt_nxt = osc_cnt_r;
		case (state_r)
			NVB_IDLE:
			begin
				if (wr_start)
				begin
					state_nxt   = NVB_PROG;
					osc_cnt_nxt = OSC_W'(WR_OSC_CYCLES);
				end
			end
			NVB_PROG:
			begin
				if (wr_done)
				begin
					state_nxt   = NVB_IDLE;                    // [RULE7]
					osc_cnt_nxt = '0;
				end
				else if (osc_tick)
				begin
					osc_cnt_nxt = osc_cnt_r - OSC_W'(1);
				end
			end
			default:
			begin
				state_nxt = NVB_IDLE;
			end
		endcase
	end

	// ************************************************************
	// Read mux, unmapped offsets answer zero
	// ************************************************************
	always_comb
	begin
		rdata_nxt = 8'h00;
		if (io_re_i && hit_ctrl)
		begin
			rdata_nxt = ctrl_word;
		end
		else if (io_re_i && hit_data)
		begin
			rdata_nxt = data_r;
		end
		else if (io_re_i && hit_alow)
		begin
			rdata_nxt = addr_wide[7:0];
		end
		else if (io_re_i && hit_ahigh)
		begin
			rdata_nxt = addr_wide[15:8];                                   // [RULE3]
		end
	end

	// ************************************************************
	// Oscillator synchroniser, first stage feeds only the second
	// ************************************************************
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
		end
		else if (ce_i)
		begin
			osc_s1_r <= osc_clk_i;
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
		end
	end

	// ************************************************************
	// Control registers
	// ************************************************************
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			addr_r       <= '0;
			data_r       <= RST_BYTE;
			arm_r        <= 1'b0;
			arm_cnt_r    <= 3'h0;
			stall_cnt_r  <= 3'h0;
			state_r      <= NVB_IDLE;
			osc_cnt_r    <= '0;
			io_rdata_o   <= 8'h00;
			cpu_stall_o  <= 1'b0;
			write_busy_o <= 1'b0;
		end
		else if (ce_i)
		begin
			addr_r       <= addr_nxt;
			data_r       <= data_nxt;
			arm_r        <= arm_nxt;
			arm_cnt_r    <= arm_cnt_nxt;
			stall_cnt_r  <= stall_cnt_nxt;
			state_r      <= state_nxt;
			osc_cnt_r    <= osc_cnt_nxt;
			io_rdata_o   <= rdata_nxt;
			cpu_stall_o  <= (stall_cnt_nxt != 3'h0);                       // [RULE5] [RULE6]
			write_busy_o <= (state_nxt == NVB_PROG);
		end
	end

	// ************************************************************
	// Write latch and array programming
	// ************************************************************
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			wr_addr_r <= '0;
			wr_data_r <= RST_BYTE;
		end
		else if (ce_i && wr_start)
		begin
			wr_addr_r <= addr_r;
			wr_data_r <= data_r;
		end
	end

	// Array holds no reset; it stands for nonvolatile storage
	always_ff @(posedge sys_clk_i)
	begin
		if (ce_i && wr_done)
		begin
			mem_r[wr_addr_r] <= wr_data_r;                                 // [RULE9]
		end
	end

endmodule

/* File: hw/nvb_pkg.sv */
// Purpose: Shared constants for the nonvolatile byte access block
// Assumes: Registers sit in the CPU I/O register space, 6-bit I/O address
// Notes:   I/O offsets and array size are named once here
package nvb_pkg;

	// ************************************************************
	// I/O space layout
	// ************************************************************
	localparam int          IO_ADDR_W        = 6;
	localparam logic [5:0]  OFS_NV_CONTROL   = 6'h10;
	localparam logic [5:0]  OFS_NV_DATA_BYTE = 6'h11;
	localparam logic [5:0]  OFS_NV_ADDR_LOW  = 6'h12;
	localparam logic [5:0]  OFS_NV_ADDR_HIGH = 6'h13;

	// ************************************************************
	// Control register fields
	// ************************************************************
	localparam int          BIT_READ_STROBE  = 0;
	localparam int          BIT_WRITE_STROBE = 1;
	localparam int          BIT_MASTER_ARM   = 2;

	// ************************************************************
	// Array geometry and reset values
	// ************************************************************
	localparam int          NV_ADDR_W        = 9;
	localparam int          NV_BYTES         = 512;
	localparam logic [7:0]  RST_BYTE         = 8'h00;

	// ************************************************************
	// Cycle counts
	// ************************************************************
	localparam logic [2:0]  ARM_HOLD_CYC     = 3'h4;
	localparam logic [2:0]  READ_STALL_CYC   = 3'h4;
	localparam logic [2:0]  WRITE_STALL_CYC  = 3'h2;
	localparam int          WRITE_OSC_CYC    = 8448;

	// Write engine states
	typedef enum logic [0:0]
	{
		NVB_IDLE = 1'b0,
		NVB_PROG = 1'b1
	} nvb_state_t;

endpackage

/* File: sim/nvb_access_assertions.sv */
// Purpose: Port assertions for the nonvolatile byte access block
// Assumes: Checks pause while ce_i is low; one access per request pulse
// Notes:   Bound to the design from the bench top file
`timescale 1ns/10ps

module nvb_access_assertions
#(
	parameter int ADDR_W        = nvb_pkg::NV_ADDR_W,
	parameter int WR_OSC_CYCLES = nvb_pkg::WRITE_OSC_CYC
)
(
	input wire logic                          sys_clk_i,
	input wire logic                          rst_i,
	input wire logic                          ce_i,
	input wire logic [nvb_pkg::IO_ADDR_W-1:0] io_addr_i,
	input wire logic                          io_we_i,
	input wire logic                          io_re_i,
	input wire logic [7:0]                    io_wdata_i,
	input wire logic                          osc_clk_i,
	input wire logic [7:0]                    io_rdata_o,
	input wire logic                          cpu_stall_o,
	input wire logic                          write_busy_o
);
	import nvb_pkg::*;

	// ********************************
	// Helper decode and arm age
	// ********************************
	logic [3:0] arm_age_r;
	wire        ctl_we = io_we_i && io_addr_i == OFS_NV_CONTROL;
	wire        ctl_re = io_re_i && io_addr_i == OFS_NV_CONTROL;

	// Cycles since the last arm write, saturating
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			arm_age_r <= 4'h0;
		else if (!ce_i)
			arm_age_r <= arm_age_r;
		else if (ctl_we && io_wdata_i[BIT_MASTER_ARM])
			arm_age_r <= 4'h1;
		else if (arm_age_r != 4'h0 && arm_age_r != 4'hF)
			arm_age_r <= arm_age_r + 4'h1;
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i || !ce_i);

	a_rdata_quiet: assert property (!io_re_i |=> io_rdata_o == 8'h00)
		else $error("read data not zero without read");
	a_high_zero: assert property (io_re_i && io_addr_i == OFS_NV_ADDR_HIGH
		|=> io_rdata_o[7:1] == 7'h00) else $error("address high upper bits set");
	a_ctrl_busy: assert property (ctl_re |=> io_rdata_o[1] == $past(write_busy_o)
		&& io_rdata_o[7:3] == 5'h00 && !io_rdata_o[0]) else $error("control word wrong");
	a_read_stall: assert property (ctl_we && io_wdata_i == 8'h01 && !write_busy_o
		|=> cpu_stall_o [*4] ##1 !cpu_stall_o) else $error("read stall length wrong");
	a_write_stall: assert property ($rose(write_busy_o)
		|-> cpu_stall_o ##1 cpu_stall_o ##1 !cpu_stall_o) else $error("write stall wrong");
	a_armed_start: assert property (ctl_we && io_wdata_i == 8'h02 && !write_busy_o
		&& arm_age_r inside {[4'h1:4'h4]} |=> write_busy_o) else $error("armed write lost");
	a_unarmed_drop: assert property (ctl_we && io_wdata_i[BIT_WRITE_STROBE]
		&& !write_busy_o && (arm_age_r == 4'h0 || arm_age_r > 4'h4) |=> !write_busy_o)
		else $error("unarmed write started");
	a_busy_span: assert property ($rose(write_busy_o)
		|-> write_busy_o [*4] ##[1:300] !write_busy_o) else $error("write time wrong");
endmodule

/* File: sim/nvb_access_tb.sv */
// Purpose: Self-checking bench for the nonvolatile byte access block
// Assumes: Shortened write time of 4 oscillator edges
// Notes:   Random addresses and data from a fixed seed
`timescale 1ns/10ps

module nvb_access_tb;
	import nvb_pkg::*;

	logic                 sys_clk_i  = 1'b0;
	logic                 rst_i      = 1'b1;
	logic                 ce_i       = 1'b1;
	logic                 io_we_i    = 1'b0;
	logic                 io_re_i    = 1'b0;
	logic                 osc_clk_i  = 1'b0;
	logic [IO_ADDR_W-1:0] io_addr_i  = 6'h00;
	logic [7:0]           io_wdata_i = 8'h00;
	logic [7:0]           io_rdata_o;
	logic                 cpu_stall_o;
	logic                 write_busy_o;
	logic [7:0]           got;
	logic [3:0]           ncyc;
	logic [7:0]           mdl [NV_BYTES];
	logic [8:0]           a;
	logic [8:0]           q [$];
	int                   failures = 0;
	int                   n_checks = 0;
	int                   k;

	// Clocks: system 8 ns, oscillator free running
	always #4 sys_clk_i = ~sys_clk_i;
	always #20 osc_clk_i = ~osc_clk_i;

	nvb_access #(.WR_OSC_CYCLES(4)) dut (.sys_clk_i, .rst_i, .ce_i, .io_addr_i,
		.io_we_i, .io_re_i, .io_wdata_i, .osc_clk_i, .io_rdata_o, .cpu_stall_o,
		.write_busy_o);

	// ********************************
	// Tasks
	// ********************************
	task results;
		$display("failures=%0d checks=%0d", failures, n_checks);
		if (failures == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask

	// Cycle count compare for stall lengths
	task chk_cyc(input logic [3:0] g, input logic [3:0] e);
		n_checks++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %0t stall %0d cycles want %0d", $time, g, e);
		end
	endtask

	// Expected control word from the arm and busy bit positions
	function automatic logic [7:0] exp_ctrl(input logic arm, input logic busy);
		exp_ctrl                   = 8'h00;
		exp_ctrl[BIT_MASTER_ARM]   = arm;
		exp_ctrl[BIT_WRITE_STROBE] = busy;
	endfunction

	// Counts stall cycles launched at the edge just passed, bounded at 8
	task cnt_stall(output logic [3:0] n);
		n = 4'h0;
		#1;
		while (n < 4'h8 && cpu_stall_o === 1'b1)
		begin
			n = n + 4'h1;
			@(posedge sys_clk_i);
			#1;
		end
	endtask

	task wr(input logic [5:0] ad, input logic [7:0] v);
		@(posedge sys_clk_i);
		io_addr_i <= ad;
		io_wdata_i <= v;
		io_we_i <= 1'b1;
		@(posedge sys_clk_i);
		io_we_i <= 1'b0;
	endtask

	task rd(input logic [5:0] ad, output logic [7:0] v);
		@(posedge sys_clk_i);
		io_addr_i <= ad;
		io_re_i <= 1'b1;
		@(posedge sys_clk_i);
		io_re_i <= 1'b0;
		#1 v = io_rdata_o;
	endtask

	// Bounded wait until neither stalled nor programming
	task settle;
		#1;
		for (k = 0; k < 400 && (write_busy_o !== 1'b0 || cpu_stall_o !== 1'b0); k++)
			#8;
		if (k == 400)
		begin
			failures++;
			$display("[ERR] %0t wait ran out", $time);
			results;
		end
	endtask

	task nv_addr(input logic [8:0] ad);
		wr(OFS_NV_ADDR_LOW, ad[7:0]);
		wr(OFS_NV_ADDR_HIGH, {7'h5A, ad[8]});
	endtask

	task nv_write(input logic [8:0] ad, input logic [7:0] v);
		nv_addr(ad);
		wr(OFS_NV_DATA_BYTE, v);
		wr(OFS_NV_CONTROL, 8'h04);
		wr(OFS_NV_CONTROL, 8'h02);
		mdl[ad] = v;
		cnt_stall(ncyc);
		chk_cyc(ncyc, 4'(WRITE_STALL_CYC));
	endtask

	task nv_read(input logic [8:0] ad);
		nv_addr(ad);
		wr(OFS_NV_CONTROL, 8'h01);
		cnt_stall(ncyc);
		chk_cyc(ncyc, 4'(READ_STALL_CYC));
		settle;
		rd(OFS_NV_DATA_BYTE, got);
		chk(got, mdl[ad]);
	endtask

	// ********************************
	// Main sequence
	// ********************************
	initial
	begin
		k = $urandom(32'h2CEEA0F2);
		repeat (20) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		rd(OFS_NV_DATA_BYTE, got);
		chk(got, RST_BYTE);
		// A data write while the clock enable is low must leave no trace
		@(posedge sys_clk_i);
		ce_i <= 1'b0;
		wr(OFS_NV_DATA_BYTE, 8'hA5);
		ce_i <= 1'b1;
		rd(OFS_NV_DATA_BYTE, got);
		chk(got, RST_BYTE);
		wr(OFS_NV_ADDR_HIGH, 8'hFF);
		rd(OFS_NV_ADDR_HIGH, got);
		chk(got, 8'h01);
		wr(OFS_NV_CONTROL, 8'h02);
		rd(OFS_NV_CONTROL, got);
		chk(got, exp_ctrl(1'b0, 1'b0));
		wr(OFS_NV_CONTROL, 8'h04);
		rd(OFS_NV_CONTROL, got);
		chk(got, exp_ctrl(1'b1, 1'b0));
		repeat (8) @(posedge sys_clk_i);
		wr(OFS_NV_CONTROL, 8'h02);
		rd(OFS_NV_CONTROL, got);
		chk(got, exp_ctrl(1'b0, 1'b0));
		for (int i = 0; i < 8; i++)
		begin
			a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'($urandom);
			q.push_back(a);
			nv_write(a, 8'($urandom));
			settle;
		end
		foreach (q[j])
			nv_read(q[j]);
		a = 9'($urandom);
		nv_write(a, 8'h3C);
		wr(OFS_NV_ADDR_LOW, ~a[7:0]);
		wr(OFS_NV_DATA_BYTE, 8'hC3);
		wr(OFS_NV_CONTROL, 8'h01);
		rd(OFS_NV_CONTROL, got);
		chk(got, exp_ctrl(1'b0, 1'b1));
		rd(OFS_NV_DATA_BYTE, got);
		chk(got, 8'hC3);
		rd(OFS_NV_ADDR_LOW, got);
		chk(got, a[7:0]);
		settle;
		nv_read(a);
		results;
	end
endmodule

bind nvb_access nvb_access_assertions #(.ADDR_W(ADDR_W), .WR_OSC_CYCLES(WR_OSC_CYCLES))
	u_chk (.sys_clk_i, .rst_i, .ce_i, .io_addr_i, .io_we_i, .io_re_i, .io_wdata_i,
	.osc_clk_i, .io_rdata_o, .cpu_stall_o, .write_busy_o);
